// ===== verilog/pwrdp_datapath.sv
// Purpose: per-phase total active power: multiply, offset, low-pass, gain
// Assumes: one sample triple per phase arrives each 125 us from same-clock logic
// Notes:   gain and offset words come from the serial register logic
//
// Overview of operation
// - power per phase covers fundamental and all harmonics, no band limiting
// - instantaneous power is current sample times voltage sample per phase
// - a low-pass filter per phase keeps only the average power
// - each phase result is a signed 24-bit readable waveform value
// - waveform value is normalized power times full-scale constant over sixteen
// - filtered power is scaled by one plus gain over two to the 23
// - gain is 24-bit two's complement, lsb weight two to the minus 23
// - gain C00000 halves the output, 400000 raises it by half
// - a signed 24-bit offset per phase removes power offset
// - one offset lsb equals one multiplier output lsb
// - a suitable offset keeps the result at zero with no load
// - arithmetic runs on 28-bit words, ports carry 32-bit words
// - gain and offset words: top nibble zero, value sign-extended to 28 bits
// - a new result per phase is produced every 125 us sample
`timescale 1ns/100ps

module pwrdp_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    localparam int unsigned PTR_W = $clog2(DEPTH);
    localparam int unsigned CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wr;
        logic [PTR_W-1:0]            rd;
        logic [CNT_W-1:0]            cnt;
        logic                        in_rdy;
        logic                        out_vld;
    } pwrdp_fifo_t;

    localparam pwrdp_fifo_t FIFO_RST = '{mem: '0, wr: '0, rd: '0, cnt: '0, in_rdy: 1'b1, out_vld: 1'b0};

    pwrdp_fifo_t q;
    pwrdp_fifo_t d;
    logic        push;
    logic        pop;

    always_comb begin
        d    = q;
        push = in_valid_i && q.in_rdy;
        pop  = q.out_vld && out_ready_i;
        if (push) begin
            d.mem[q.wr] = in_data_i;
            d.wr        = (q.wr == PTR_LAST) ? '0 : q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = (q.rd == PTR_LAST) ? '0 : q.rd + 1'b1;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
        // flags registered so ready and valid are clean flop outputs
        d.in_rdy  = (d.cnt != CNT_FULL);
        d.out_vld = (d.cnt != '0);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= FIFO_RST;
        end else begin
            q <= d;
        end
    end

    assign in_ready_o  = q.in_rdy;
    assign out_valid_o = q.out_vld;
    assign out_data_o  = q.mem[q.rd];
endmodule

module pwrdp_datapath (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        samp_valid_i,
    output logic             samp_ready_o,
    input  wire logic [23:0] volt_a_i,
    input  wire logic [23:0] volt_b_i,
    input  wire logic [23:0] volt_c_i,
    input  wire logic [23:0] curr_a_i,
    input  wire logic [23:0] curr_b_i,
    input  wire logic [23:0] curr_c_i,
    input  wire logic [31:0] phase_a_power_gain_i,
    input  wire logic [31:0] phase_b_power_gain_i,
    input  wire logic [31:0] phase_c_power_gain_i,
    input  wire logic [31:0] phase_a_power_offset_i,
    input  wire logic [31:0] phase_b_power_offset_i,
    input  wire logic [31:0] phase_c_power_offset_i,
    output logic [31:0]      phase_a_power_sample_o,
    output logic [31:0]      phase_b_power_sample_o,
    output logic [31:0]      phase_c_power_sample_o,
    output logic             power_valid_o
);
    localparam int unsigned NP = pwrdp_pkg::NPHASE;
    localparam int unsigned SW = pwrdp_pkg::SAMPLE_W;
    localparam int unsigned WW = pwrdp_pkg::WORD_W;
    localparam int unsigned PW = pwrdp_pkg::PORT_W;
    localparam int unsigned AW = pwrdp_pkg::ACC_W;
    localparam int unsigned XW = pwrdp_pkg::WIDE_W;

    typedef struct packed {
        pwrdp_pkg::pwrdp_state_t st;
        logic [NP-1:0][SW-1:0]   volt;
        logic [NP-1:0][SW-1:0]   curr;
        logic [NP-1:0][WW-1:0]   pwr;
        logic [NP-1:0][AW-1:0]   acc;
        logic [NP-1:0][PW-1:0]   wave;
        logic                    valid;
    } pwrdp_top_t;

    localparam pwrdp_top_t TOP_RST = '{st: pwrdp_pkg::PWRDP_IDLE, volt: '0, curr: '0, pwr: '0,
                                       acc: '0, wave: '0, valid: 1'b0};

    // clamp instead of wrap so a large offset or gain cannot flip the sign
    function automatic logic [WW-1:0] sat_word(input logic signed [XW-1:0] x);
        logic [WW-1:0] r;
        r = x[WW-1:0];
        if (x > XW'(pwrdp_pkg::WORD_MAX)) begin
            r = pwrdp_pkg::WORD_MAX;
        end else if (x < XW'(pwrdp_pkg::WORD_MIN)) begin
            r = pwrdp_pkg::WORD_MIN;
        end
        return r;
    endfunction

    pwrdp_top_t                       q;
    pwrdp_top_t                       d;
    logic                             fifo_ready;
    logic                             fifo_valid;
    logic [pwrdp_pkg::FIFO_W-1:0]     fifo_in;
    logic [pwrdp_pkg::FIFO_W-1:0]     fifo_out;
    logic [NP-1:0][PW-1:0]            gain_word;
    logic [NP-1:0][PW-1:0]            offs_word;
    logic [NP-1:0][WW-1:0]            mult_off;
    logic [NP-1:0][AW-1:0]            acc_next;
    logic [NP-1:0][SW-1:0]            wave_val;

    assign gain_word = {phase_c_power_gain_i, phase_b_power_gain_i, phase_a_power_gain_i};
    assign offs_word = {phase_c_power_offset_i, phase_b_power_offset_i, phase_a_power_offset_i};
    assign fifo_in   = {curr_c_i, volt_c_i, curr_b_i, volt_b_i, curr_a_i, volt_a_i};

    pwrdp_fifo #(
        .WIDTH (pwrdp_pkg::FIFO_W),
        .DEPTH (pwrdp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (samp_valid_i),
        .in_data_i   (fifo_in),
        .in_ready_o  (samp_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_out),
        .out_ready_i (fifo_ready)
    );

    // stall the fifo while a sample is still in the pipeline
    assign fifo_ready = (q.st == pwrdp_pkg::PWRDP_IDLE);

    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_phase
            logic signed [XW-1:0] prod;
            logic signed [XW-1:0] offs;
            logic signed [XW-1:0] acc_x;
            logic signed [XW-1:0] in_x;
            logic signed [XW-1:0] filt;
            logic signed [XW-1:0] gain;
            logic signed [XW-1:0] gained;
            logic [WW-1:0]        res;
            // full-band product, no filtering ahead of it
            assign prod  = ($signed(XW'($signed(q.volt[p]))) * $signed(XW'($signed(q.curr[p]))))
                           >>> pwrdp_pkg::PROD_SHIFT;
            // low 28 bits carry the sign-extended setting
            assign offs  = XW'($signed(offs_word[p][WW-1:0]));
            // offset lsb weighs one multiplier lsb
            assign mult_off[p] = sat_word(prod + offs);
            // first-order low-pass, fraction bits kept to avoid a dead band
            assign acc_x = XW'($signed(q.acc[p]));
            assign in_x  = XW'($signed(q.pwr[p])) <<< pwrdp_pkg::LPF_SHIFT;
            assign acc_next[p] = AW'(acc_x + ((in_x - acc_x) >>> pwrdp_pkg::LPF_SHIFT));
            assign filt  = acc_x >>> pwrdp_pkg::LPF_SHIFT;
            // out = filt * (1 + gain / 2^23)
            assign gain   = XW'($signed(gain_word[p][WW-1:0]));
            assign gained = filt + ((filt * gain) >>> pwrdp_pkg::GAIN_FRAC);
            assign res    = sat_word(gained);
            // scaled to full-scale constant over sixteen
            assign wave_val[p] = SW'($signed(res) >>> pwrdp_pkg::WAVE_SHIFT);
        end
    endgenerate

    always_comb begin
        d       = q;
        d.valid = 1'b0;
        case (q.st)
            pwrdp_pkg::PWRDP_IDLE: begin
                if (fifo_valid) begin
                    for (int k = 0; k < NP; k++) begin
                        d.volt[k] = fifo_out[k*pwrdp_pkg::PROD_W + pwrdp_pkg::VOLT_POS +: SW];
                        d.curr[k] = fifo_out[k*pwrdp_pkg::PROD_W + pwrdp_pkg::CURR_POS +: SW];
                    end
                    d.st = pwrdp_pkg::PWRDP_MULT;
                end
            end
            pwrdp_pkg::PWRDP_MULT: begin
                d.pwr = mult_off;
                d.st  = pwrdp_pkg::PWRDP_FILT;
            end
            pwrdp_pkg::PWRDP_FILT: begin
                d.acc = acc_next;
                d.st  = pwrdp_pkg::PWRDP_GAIN;
            end
            pwrdp_pkg::PWRDP_GAIN: begin
                // one fresh result per sample period
                for (int k = 0; k < NP; k++) begin
                    d.wave[k] = {pwrdp_pkg::WAVE_PAD, wave_val[k]};
                end
                d.valid = 1'b1;
                d.st    = pwrdp_pkg::PWRDP_IDLE;
            end
            default: begin
                d.st = pwrdp_pkg::PWRDP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= TOP_RST;
        end else begin
            q <= d;
        end
    end

    assign phase_a_power_sample_o = q.wave[0];
    assign phase_b_power_sample_o = q.wave[1];
    assign phase_c_power_sample_o = q.wave[2];
    assign power_valid_o          = q.valid;
endmodule

// ===== verilog/pwrdp_pkg.sv
// Purpose: constants for the per-phase active power datapath
// Assumes: 24-bit signed converter samples, 28-bit internal words
// Notes:   register words are 32 bits with zero upper nibble
package pwrdp_pkg;
    localparam int unsigned NPHASE      = 3;
    localparam int unsigned SAMPLE_W    = 24;
    localparam int unsigned WORD_W      = 28;
    localparam int unsigned PORT_W      = 32;
    localparam int unsigned PROD_W      = 2 * SAMPLE_W;
    localparam int unsigned PROD_SHIFT  = 19;
    localparam int unsigned LPF_SHIFT   = 8;
    localparam int unsigned ACC_W       = WORD_W + LPF_SHIFT;
    localparam int unsigned GAIN_FRAC   = 23;
    localparam int unsigned WAVE_SHIFT  = 4;
    localparam int unsigned WIDE_W      = 64;
    localparam int unsigned FIFO_DEPTH  = 16;
    localparam int unsigned FIFO_W      = NPHASE * PROD_W;
    localparam int unsigned VOLT_POS    = 0;
    localparam int unsigned CURR_POS    = SAMPLE_W;
    localparam logic signed [WORD_W-1:0] WORD_MAX = 28'h7FFFFFF;
    localparam logic signed [WORD_W-1:0] WORD_MIN = 28'h8000000;
    localparam logic [PORT_W-SAMPLE_W-1:0] WAVE_PAD = 8'h00;
    localparam int unsigned SAMPLE_PERIOD_NS = 125000;
    localparam int unsigned CLK_PERIOD_NS    = 100;
    localparam int unsigned SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        PWRDP_IDLE = 4'h1,
        PWRDP_MULT = 4'h2,
        PWRDP_FILT = 4'h4,
        PWRDP_GAIN = 4'h8
    } pwrdp_state_t;
endpackage

// ===== dv/pwrdp_checker.sv
// Purpose: port-level checks for the power datapath
// Assumes: one clock, asynchronous active-high reset
// Notes:   pend_q counts samples taken but not yet reported
`timescale 1ns/100ps
module pwrdp_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        samp_valid_i,
    input wire logic        samp_ready_o,
    input wire logic [31:0] phase_a_power_sample_o,
    input wire logic [31:0] phase_b_power_sample_o,
    input wire logic [31:0] phase_c_power_sample_o,
    input wire logic        power_valid_o
);
    logic [5:0] pend_q;
    logic [5:0] pend_d;
    always_comb begin
        pend_d = pend_q + {5'h00, samp_valid_i && samp_ready_o} - {5'h00, power_valid_o};
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_q <= 6'h00;
        end else begin
            pend_q <= pend_d;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence take_s;
        samp_valid_i && samp_ready_o;
    endsequence
    sequence report_s;
        ##[1:80] power_valid_o;
    endsequence
    pad_zero_a: assert property ((phase_a_power_sample_o[31:24] | phase_b_power_sample_o[31:24]
        | phase_c_power_sample_o[31:24]) == 8'h00) else $error("sample pad bits not zero");
    pulse_gap_a: assert property (power_valid_o |=> !power_valid_o [*3])
        else $error("result pulse too long or too close");
    out_hold_a: assert property (!power_valid_o |-> $stable(phase_a_power_sample_o)
        && $stable(phase_b_power_sample_o) && $stable(phase_c_power_sample_o)) else $error("result moved");
    reply_bound_a: assert property (take_s |-> report_s)
        else $error("taken sample never reported");
    first_lat_a: assert property (samp_valid_i && samp_ready_o && pend_q == 6'h00 |-> ##5 power_valid_o)
        else $error("idle sample not reported in five cycles");
    no_spurious_a: assert property (power_valid_o |-> pend_q != 6'h00)
        else $error("result without a sample");
    room_ready_a: assert property (pend_q < 6'h10 |-> samp_ready_o)
        else $error("refused with room left");
    pend_bound_a: assert property (pend_q <= 6'h11)
        else $error("more samples held than buffer allows");
    reset_zero_a: assert property ($fell(rst_i) |-> samp_ready_o && !power_valid_o
        && (phase_a_power_sample_o | phase_b_power_sample_o | phase_c_power_sample_o) == 32'h00000000)
        else $error("reset values wrong");
endmodule

// ===== dv/pwrdp_source.sv
// Purpose: model of the converter chain feeding sample triples
// Assumes: data is held with valid until the block takes it
// Notes:   idle lines carry the inverse so stale values never match
`timescale 1ns/100ps
module pwrdp_source #(
    parameter int unsigned GAP = pwrdp_pkg::SAMPLE_CYCLES - 2
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        en_i,
    input  wire logic        slow_i,
    input  wire logic        ready_i,
    input  wire logic [23:0] volt_set_i [3],
    input  wire logic [23:0] curr_set_i [3],
    output logic             valid_o,
    output logic [23:0]      volt_o [3],
    output logic [23:0]      curr_o [3],
    output int               taken_o
);
    int gap_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
            gap_q   <= 0;
            taken_o <= 0;
        end else if (valid_o && ready_i) begin
            taken_o <= taken_o + 1;
            valid_o <= en_i && !slow_i;
            gap_q   <= slow_i ? GAP : 0;
        end else if (gap_q != 0) begin
            gap_q <= slow_i ? gap_q - 1 : 0;
        end else if (!valid_o) begin
            valid_o <= en_i;
        end
    end
    for (genvar k = 0; k < 3; k++) begin : g_ln
        assign volt_o[k] = valid_o ? volt_set_i[k] : ~volt_set_i[k];
        assign curr_o[k] = valid_o ? curr_set_i[k] : ~curr_set_i[k];
    end
endmodule

// ===== dv/pwrdp_datapath_tb.sv
// Purpose: self-checking bench for the power datapath
// Assumes: source model feeds held sample triples
// Notes:   filter settles slowly, so results are compared within a small band
`timescale 1ns/100ps
module pwrdp_datapath_tb;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic             en    = 1'b0;
    logic             slow  = 1'b0;
    logic             full  = 1'b0;
    logic [23:0]      vs [3] = '{24'h400000, 24'h400000, 24'h400000};
    logic [23:0]      cs [3] = '{24'h400000, 24'h400000, 24'h400000};
    logic [31:0]      gn [3] = '{32'h00000000, 32'h00000000, 32'h00000000};
    logic [31:0]      os [3] = '{32'h00000000, 32'h00000000, 32'h00000000};
    wire logic [23:0] v [3];
    wire logic [23:0] c [3];
    wire logic [31:0] p [3];
    wire logic        sv;
    wire logic        sr;
    wire logic        pv;
    int               taken;
    int               err_count = 0;
    int               checked   = 0;
    int               pulses    = 0;
    int               cyc       = 0;
    always #50 clk_i = ~clk_i;
    pwrdp_source src (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .slow_i(slow), .ready_i(sr), .volt_set_i(vs),
        .curr_set_i(cs), .valid_o(sv), .volt_o(v), .curr_o(c), .taken_o(taken));
    pwrdp_datapath uut (.clk_i(clk_i), .rst_i(rst_i), .samp_valid_i(sv), .samp_ready_o(sr),
        .volt_a_i(v[0]), .volt_b_i(v[1]), .volt_c_i(v[2]), .curr_a_i(c[0]), .curr_b_i(c[1]), .curr_c_i(c[2]),
        .phase_a_power_gain_i(gn[0]), .phase_b_power_gain_i(gn[1]), .phase_c_power_gain_i(gn[2]),
        .phase_a_power_offset_i(os[0]), .phase_b_power_offset_i(os[1]), .phase_c_power_offset_i(os[2]),
        .phase_a_power_sample_o(p[0]), .phase_b_power_sample_o(p[1]), .phase_c_power_sample_o(p[2]),
        .power_valid_o(pv));
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pulses <= 0;
        end else begin
            pulses <= pulses + int'(pv === 1'b1);
            full   <= full | (sr === 1'b0);
        end
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            results();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic fail(input string m);
        err_count++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic cmp_pow(input logic [31:0] got, input logic signed [23:0] exp);
        logic signed [24:0] d;
        d = $signed(got[23:0]) - exp;
        checked++;
        if ($isunknown(got) || got[31:24] !== 8'h00 || d > 25'sd20 || d < -25'sd20) fail("power value off");
    endtask
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) fail("value mismatch");
    endtask
    // drain bound covers a full buffer at four cycles a sample
    task automatic run(input int n);
        int t0;
        t0 = taken;
        en = 1'b1;
        for (int k = 0; k < 1300 * n && taken - t0 < n; k++) step(1);
        en = 1'b0;
        for (int k = 0; k < 2000 && pulses != taken; k++) step(1);
    endtask
    task automatic t_reset;
        rst_i = 1'b1;
        step(10);
        rst_i = 1'b0;
        step(1);
        cmp_val(32'(sr), 32'h00000001);
        cmp_val(p[0] | p[1] | p[2] | 32'(pv), 32'h00000000);
        $display("test reset done");
    endtask
    task automatic t_gain;
        gn = '{32'h0FFFFFFF, 32'h0FC00000, 32'h00400000};
        run(4000);
        cmp_pow(p[0], 24'sh200000);
        cmp_pow(p[1], 24'sh100000);
        cmp_pow(p[2], 24'sh300000);
        cmp_val(32'(full), 32'h00000001);
        cmp_val(pulses, taken);
        $display("test gain done");
    endtask
    task automatic t_off;
        vs = '{24'h400000, 24'hC00000, 24'h7FFFFF};
        cs = '{24'h000400, 24'h400000, 24'h7FFFFF};
        gn = '{32'h00000000, 32'h00000000, 32'h007FFFFF};
        os = '{32'h0FFFE000, 32'h00000000, 32'h00000000};
        run(4000);
        cmp_pow(p[0], 24'sh000000);
        cmp_pow(p[1], 24'shE00000);
        cmp_pow(p[2], 24'sh7FFFFF);
        $display("test offset done");
    endtask
    task automatic t_slow;
        slow = 1'b1;
        run(4);
        cmp_val(pulses, taken);
        cmp_pow(p[0], 24'sh000000);
        slow = 1'b0;
        en   = 1'b1;
        step(30);
        en   = 1'b0;
        $display("test slow done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        t_reset();
        t_gain();
        t_off();
        t_slow();
        t_reset();
        results();
    end
endmodule
bind pwrdp_datapath pwrdp_checker chk (.clk_i(clk_i), .rst_i(rst_i), .samp_valid_i(samp_valid_i),
    .samp_ready_o(samp_ready_o), .phase_a_power_sample_o(phase_a_power_sample_o),
    .phase_b_power_sample_o(phase_b_power_sample_o), .phase_c_power_sample_o(phase_c_power_sample_o),
    .power_valid_o(power_valid_o));
